// >>> verilog/general_purpose_pin_mux.v
/*
 * General-purpose pin group with alternate-function multiplexing:
 * two downstream reset outputs and three expander interrupt inputs.
 * Assumes configuration is driven by same-clock logic (software, slave
 * SMBus or EEPROM loader) and the expander read is done by a master
 * SMBus engine outside, which takes a request and acknowledges it.
 */
`timescale 1ns/1ps
`include "gpio_mux_defines.vh"
module general_purpose_pin_mux (
  // Clock and reset
  input  wire                     sys_clk,
  input  wire                     sys_rst,
  // Software configuration writes
  input  wire                     swCfgWe,
  input  wire [`GP_WIDTH-1:0]     swDirIn,
  input  wire [`GP_WIDTH-1:0]     swOutIn,
  input  wire [4:0]               swAltIn,
  // Slave SMBus alternate-enable write
  input  wire                     smbAltWe,
  input  wire [4:0]               smbAltIn,
  // EEPROM load alternate-enable write
  input  wire                     eeAltWe,
  input  wire [4:0]               eeAltIn,
  // Downstream reset requests from port logic, active high
  input  wire                     port2ResetReq,
  input  wire                     port4ResetReq,
  // Master SMBus engine handshake
  input  wire                     expReadAck,
  output reg                      expReadReq,
  output reg  [1:0]               expReadSel,
  // Readback of state
  output reg  [`GP_WIDTH-1:0]     gpInValue,
  output reg  [4:0]               altEnable,
  output reg  [`GP_NUM_EXP-1:0]   expPending,
  // Pins: input, output, output enable (high while driving)
  input  wire [`GP_WIDTH-1:0]     gpPinIn,
  output reg  [`GP_WIDTH-1:0]     gpPinOut,
  output reg  [`GP_WIDTH-1:0]     gpPinOe
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg  [`GP_WIDTH-1:0]   gpDir_r;       // 1 = output
  reg  [`GP_WIDTH-1:0]   gpOut_r;       // Software output values
  reg  [4:0]             alt_r;         // Alternate enables
  reg  [4:0]             altNxt;
  wire [`GP_WIDTH-1:0]   pinSync;       // Synchronised pin levels
  reg  [`GP_WIDTH-1:0]   outNxt;
  reg  [`GP_WIDTH-1:0]   oeNxt;
  reg  [`GP_NUM_EXP-1:0] intPrev_r;     // Previous interrupt levels
  wire [`GP_NUM_EXP-1:0] intLevelN;     // Expander interrupt, active low
  wire [`GP_NUM_EXP-1:0] intFall;       // Assertion events
  reg  [`GP_NUM_EXP-1:0] pend_r;
  reg  [`GP_NUM_EXP-1:0] pendNxt;
  reg  [1:0]             sel_r;

  // Read state machine, one-hot
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  reg [1:0] state_r;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  pin_sync #(
    .WIDTH (`GP_WIDTH)
  ) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .asyncIn (gpPinIn),
    .syncOut (pinSync)
  );

  // Expander interrupts on pins 2..4, low when asserted
  assign intLevelN = pinSync[`GP_PIN_EXP2_INT:`GP_PIN_EXP0_INT];
  // Falling edge qualified by the pin's alternate enable
  assign intFall = intPrev_r & ~intLevelN & alt_r[4:2];

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // Later source wins when several write in one cycle; EEPROM load
  // normally happens alone after reset so the order rarely matters.
  always @* begin
    altNxt = alt_r;
    if (swCfgWe) begin
      altNxt = swAltIn;
    end
    if (smbAltWe) begin
      altNxt = smbAltIn;
    end
    if (eeAltWe) begin
      altNxt = eeAltIn;
    end
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpDir_r <= `GP_DIR_RESET;
      gpOut_r <= `GP_OUT_RESET;
      alt_r   <= `GP_ALT_RESET;
    end else begin
      if (swCfgWe) begin
        gpDir_r <= swDirIn;
        gpOut_r <= swOutIn;
      end
      alt_r <= altNxt;
    end
  end

  // ****************************************************************
  // Pin output multiplexer
  // ****************************************************************
  always @* begin
    outNxt = gpOut_r;
    oeNxt  = gpDir_r;
    if (alt_r[`ALT_PORT2_RST]) begin
      outNxt[`GP_PIN_PORT2_RST] = ~port2ResetReq;
      oeNxt[`GP_PIN_PORT2_RST]  = 1'b1;
    end
    if (alt_r[`ALT_PORT4_RST]) begin
      outNxt[`GP_PIN_PORT4_RST] = ~port4ResetReq;
      oeNxt[`GP_PIN_PORT4_RST]  = 1'b1;
    end
    if (alt_r[2]) begin
      oeNxt[`GP_PIN_EXP0_INT] = 1'b0;
    end
    if (alt_r[3]) begin
      oeNxt[`GP_PIN_EXP1_INT] = 1'b0;
    end
    if (alt_r[4]) begin
      oeNxt[`GP_PIN_EXP2_INT] = 1'b0;
    end
  end

  // Registered pins and readback
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpPinOut  <= `GP_OUT_RESET;
      gpPinOe   <= `GP_DIR_RESET;
      gpInValue <= {`GP_WIDTH{1'b0}};
      altEnable <= `GP_ALT_RESET;
    end else begin
      gpPinOut  <= outNxt;
      gpPinOe   <= oeNxt;
      gpInValue <= pinSync;
      altEnable <= alt_r;
    end
  end

  // ****************************************************************
  // Expander interrupt capture and read requests
  // ****************************************************************
  // Pending bits: a new event in the cycle its bit is served wins.
  always @* begin
    pendNxt = pend_r;
    if (state_r == ST_WAIT && expReadAck) begin
      pendNxt[sel_r] = 1'b0;
    end
    pendNxt = pendNxt | intFall;
  end

  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      intPrev_r  <= {`GP_NUM_EXP{1'b1}};
      pend_r     <= {`GP_NUM_EXP{1'b0}};
      state_r    <= ST_IDLE;
      sel_r      <= 2'h0;
      expReadReq <= 1'b0;
      expReadSel <= 2'h0;
      expPending <= {`GP_NUM_EXP{1'b0}};
    end else begin
      intPrev_r  <= intLevelN;
      pend_r     <= pendNxt;
      expPending <= pendNxt;
      case (state_r)
        ST_IDLE: begin
          // Lowest expander number served first
          if (pend_r[0]) begin
            sel_r <= 2'h0;
            expReadSel <= 2'h0;
            expReadReq <= 1'b1;
            state_r <= ST_WAIT;
          end else if (pend_r[1]) begin
            sel_r <= 2'h1;
            expReadSel <= 2'h1;
            expReadReq <= 1'b1;
            state_r <= ST_WAIT;
          end else if (pend_r[2]) begin
            sel_r <= 2'h2;
            expReadSel <= 2'h2;
            expReadReq <= 1'b1;
            state_r <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Request holds until the engine acknowledges
          if (expReadAck) begin
            expReadReq <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          expReadReq <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> verilog/gpio_mux_defines.vh
/*
 * Constants for the general-purpose pin multiplexer: pin count, pin
 * positions of the alternate functions and reset values.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef GPIO_MUX_DEFINES_VH
`define GPIO_MUX_DEFINES_VH

// Pin group width
`define GP_WIDTH            11
// Alternate function pin positions
`define GP_PIN_PORT2_RST    0
`define GP_PIN_PORT4_RST    1
`define GP_PIN_EXP0_INT     2
`define GP_PIN_EXP1_INT     3
`define GP_PIN_EXP2_INT     4
// Number of expander interrupt inputs
`define GP_NUM_EXP          3
// Reset values: all pins inputs, outputs low, no alternate function
`define GP_DIR_RESET        11'h000
`define GP_OUT_RESET        11'h000
`define GP_ALT_RESET        5'h00
// Alternate function enable bit positions
`define ALT_PORT2_RST       0
`define ALT_PORT4_RST       1
`define ALT_EXP0_INT        2

`endif

// >>> verilog/pin_sync.v
/*
 * Two flip-flop synchroniser for a bus of pin inputs.
 * Assumes the pins are asynchronous to sys_clk; output is safe to use.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 11
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             sys_rst,
  // Raw and synchronised levels
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  // First stage, read only by the second stage
  reg [WIDTH-1:0] meta_r;

  // ****************************************************************
  // Two-stage capture
  // ****************************************************************
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r  <= {WIDTH{1'b1}};
      syncOut <= {WIDTH{1'b1}};
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

// >>> bench/gp_mux_sva.sv
/* Port checker for the pin mux.
   Assumes one clock domain; bound onto the top module below. */
`timescale 1ns/1ps
module gp_mux_sva (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Inputs watched
  input wire logic        swCfgWe,
  input wire logic [10:0] swDirIn,
  input wire logic        port2ResetReq,
  input wire logic        port4ResetReq,
  input wire logic        expReadAck,
  // Outputs watched
  input wire logic        expReadReq,
  input wire logic [1:0]  expReadSel,
  input wire logic [10:0] gpInValue,
  input wire logic [4:0]  altEnable,
  input wire logic [2:0]  expPending,
  input wire logic [10:0] gpPinOut,
  input wire logic [10:0] gpPinOe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Pins
  // ****************************************
  chk_rst_drive: assert property ((gpPinOe[1:0] & altEnable[1:0]) == altEnable[1:0])
    else $error("reset pin not driven");
  chk_port2_level: assert property (altEnable[0] && $past(altEnable[0]) |->
    gpPinOut[0] == !$past(port2ResetReq)) else $error("port 2 reset level");
  chk_port4_level: assert property (altEnable[1] && $past(altEnable[1]) |->
    gpPinOut[1] == !$past(port4ResetReq)) else $error("port 4 reset level");
  chk_int_input: assert property ((altEnable[4:2] & gpPinOe[4:2]) == 3'h0)
    else $error("interrupt pin driven");
  chk_plain_cfg: assert property (swCfgWe |-> ##2
    gpPinOe[10:5] == $past(swDirIn[10:5], 2)) else $error("plain pin direction");
  // ****************************************
  // Expander reads
  // ****************************************
  for (genvar g = 0; g < 3; g++) begin : gDet
    chk_int_detect: assert property ($fell(gpInValue[g+2]) && altEnable[g+2] |->
      ##[0:2] expPending[g]) else $error("expander event missed");
  end
  chk_req_hold: assert property (expReadReq && !expReadAck |=>
    expReadReq && $stable(expReadSel)) else $error("read request dropped");
  chk_req_drop: assert property (expReadReq && expReadAck |=> !expReadReq)
    else $error("read request kept");
  chk_sel_pend: assert property (expReadReq |->
    expReadSel != 2'h3 && expPending[expReadSel]) else $error("read of idle expander");
  chk_pend_req: assert property (expPending != 3'h0 && !expReadReq |-> ##[1:3] expReadReq)
    else $error("pending event not read");
endmodule
bind general_purpose_pin_mux gp_mux_sva gp_mux_sva_inst (.sys_clk, .sys_rst, .swCfgWe,
  .swDirIn, .port2ResetReq, .port4ResetReq, .expReadAck, .expReadReq, .expReadSel,
  .gpInValue, .altEnable, .expPending, .gpPinOut, .gpPinOe);

// >>> bench/gp_expander_model.sv
/* Far side: three hot-plug expanders and the master bus read engine.
   Assumes one clock; an expander holds its interrupt until it is read. */
`timescale 1ns/1ps
module gp_expander_model (
  // Clock
  input  wire logic       sys_clk,
  // Read handshake
  input  wire logic       expReadReq,
  input  wire logic [1:0] expReadSel,
  output logic            expReadAck,
  // Bench commands
  input  wire logic [2:0] fire,
  input  wire logic       slow,
  // Interrupt lines, low active
  output logic [2:0]      expIntN
);
  integer cnt = 0;          // Wait cycles so far
  wire    ackNow;           // Read completes at this edge
  initial expReadAck = 1'b0;
  initial expIntN = 3'h7;
  assign ackNow = expReadReq && !expReadAck && (cnt >= (slow ? 4 : 0));
  // Engine answers at once or after four waits; ack is one cycle.
  // A read releases its line, which wins over a new fire of that line.
  always @(posedge sys_clk) begin
    expReadAck <= ackNow;
    expIntN <= (expIntN & ~fire) | (ackNow ? (3'h1 << expReadSel) : 3'h0);
    if (expReadReq && !expReadAck) begin
      cnt <= ackNow ? 0 : cnt + 1;
    end
  end
endmodule

// >>> bench/general_purpose_pin_mux_tb.sv
/* Self-checking bench: plain pins, enable paths, reset pins, expander reads.
   Assumes the expander model and the bound checker are compiled before. */
`timescale 1ns/1ps
module general_purpose_pin_mux_tb;
  reg         sys_clk = 1'b0, sys_rst = 1'b1, slow = 1'b0;
  reg         swCfgWe = 1'b0, smbAltWe = 1'b0, eeAltWe = 1'b0;
  reg         port2ResetReq = 1'b0, port4ResetReq = 1'b0;
  reg  [10:0] swDirIn = 11'h000, swOutIn = 11'h000, benchDrv = 11'h000;
  reg  [4:0]  swAltIn = 5'h00, smbAltIn = 5'h00, eeAltIn = 5'h00;
  reg  [2:0]  fire = 3'h0;
  wire        expReadAck, expReadReq;
  wire [1:0]  expReadSel;
  wire [2:0]  expIntN, expPending;
  wire [4:0]  altEnable;
  wire [10:0] gpInValue, gpPinOut, gpPinOe, pinLvl;
  integer     errors = 0, numChecks = 0, seed = 3, i, k;
  reg  [1:0]  expQ[$];      // Expected read order
  // Wire level: device drives when enabled, far side otherwise
  assign pinLvl = (gpPinOe & gpPinOut) | (~gpPinOe & {benchDrv[10:5], expIntN, benchDrv[1:0]});
  always #20 sys_clk = ~sys_clk;
  general_purpose_pin_mux general_purpose_pin_mux_inst (.sys_clk, .sys_rst, .swCfgWe,
    .swDirIn, .swOutIn, .swAltIn, .smbAltWe, .smbAltIn, .eeAltWe, .eeAltIn,
    .port2ResetReq, .port4ResetReq, .expReadAck, .expReadReq, .expReadSel, .gpInValue,
    .altEnable, .expPending, .gpPinIn(pinLvl), .gpPinOut, .gpPinOe);
  gp_expander_model gp_expander_model_inst (.sys_clk, .expReadReq, .expReadSel,
    .expReadAck, .fire, .slow, .expIntN);
  task check(input [10:0] got, input [10:0] exp);
    begin
      numChecks = numChecks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", numChecks, errors);
      if (errors == 0 && numChecks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Write on path p (0 software, 1 slave bus, 2 loader, 3 all at once)
  task cfg(input [1:0] p, input [10:0] dir, input [10:0] out, input [4:0] alt);
    begin
      @(posedge sys_clk);
      i = $random(seed);
      benchDrv <= i[10:0];
      port2ResetReq <= i[11];
      port4ResetReq <= i[12];
      swDirIn <= dir;
      swOutIn <= out;
      swAltIn <= (p == 2'h3) ? ~alt : alt;
      smbAltIn <= (p == 2'h1) ? alt : ~alt;
      eeAltIn <= alt;
      swCfgWe <= (p == 2'h0) || (p == 2'h3);
      smbAltWe <= (p == 2'h1) || (p == 2'h3);
      eeAltWe <= (p >= 2'h2);
      @(posedge sys_clk);
      swCfgWe <= 1'b0;
      smbAltWe <= 1'b0;
      eeAltWe <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
    end
  endtask
  // Bounded wait until every expected read has been seen
  task drain;
    integer n;
    begin
      for (n = 0; n < 300 && expQ.size() != 0; n = n + 1) @(posedge sys_clk);
      if (expQ.size() != 0) begin
        errors = errors + 1;
        final_report;
      end
    end
  endtask
  // Results: each acknowledged read is matched against the oldest note
  always @(posedge sys_clk) begin
    if (!sys_rst && expReadReq && expReadAck) begin
      if (expQ.size() == 0) check({9'h000, expReadSel}, 11'h7FF);
      else check({9'h000, expReadSel}, {9'h000, expQ.pop_front()});
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    check(gpPinOe | {6'h00, altEnable}, 11'h000);
    for (k = 0; k < 4; k = k + 1) begin
      cfg(2'h0, $random(seed), 11'h2A5 ^ k[10:0], 5'h00);
      check(gpPinOe, swDirIn);
      check(gpPinOut, 11'h2A5 ^ k[10:0]);
      check(gpInValue, pinLvl);
    end
    $display("test plain pins done");
    for (k = 0; k < 4; k = k + 1) begin
      cfg(k[1:0], 11'h7FF, 11'h000, 5'h1C ^ k[4:0]);
      check({6'h00, altEnable}, {6'h00, 5'h1C ^ k[4:0]});
      check(gpPinOe, 11'h7E3);
      check(gpPinOut[1:0], {k[1] & ~port4ResetReq, k[0] & ~port2ResetReq});
    end
    $display("test alternate pins done");
    fire <= 3'h5;
    expQ.push_back(2'h0);
    expQ.push_back(2'h2);
    @(posedge sys_clk);
    fire <= 3'h0;
    drain;
    slow <= 1'b1;
    fire <= 3'h2;
    expQ.push_back(2'h1);
    @(posedge sys_clk);
    fire <= 3'h0;
    drain;
    $display("test expander reads done");
    cfg(2'h0, 11'h000, 11'h000, 5'h00);
    @(posedge sys_clk);
    fire <= 3'h7;
    repeat (12) @(posedge sys_clk);
    #1;
    check({8'h00, expPending}, 11'h000);
    $display("test ignored events done");
    final_report;
  end
endmodule
